// file: vptf_defs.vh
`ifndef VPTF_DEFS_VH
`define VPTF_DEFS_VH

// Tag protocol identifiers
`define VPTF_TPID_CTAG     16'h8100
`define VPTF_TPID_STAG     16'h88A8

// Port type encodings
`define VPTF_TYPE_CUSTOMER 2'h0
`define VPTF_TYPE_SERVICE  2'h1
`define VPTF_TYPE_CUSTOM   2'h2

// Frame layout, in bytes
`define VPTF_ADDR_BYTES    5'h0C
`define VPTF_HDR_BYTES     5'h0E
`define VPTF_UNTAG_LEN     5'h12
`define VPTF_TPID_HI_IDX   4'hC
`define VPTF_TPID_LO_IDX   4'hD

// Inserted tag priority and drop-eligible bits
`define VPTF_TCI_PCP_DEI   4'h0

`endif

// file: vptf_tag_classify.v
`timescale 1ns/1ps
`default_nettype none
`include "vptf_defs.vh"

module vptf_tag_classify (
  // Port setting
  input  wire [1:0]  i_port_type,
  input  wire [15:0] i_custom_tpid,
  // Received ethertype field
  input  wire [15:0] i_ethertype,
  // Decision
  output wire        o_tagged,
  output wire        o_discard,
  output reg  [15:0] o_port_tpid
);

  wire is_ctag;
  wire is_stag;
  wire customer;

  assign is_ctag  = (i_ethertype == `VPTF_TPID_CTAG);
  assign is_stag  = (i_ethertype == `VPTF_TPID_STAG);
  // Reserved type code behaves as customer
  assign customer = (i_port_type != `VPTF_TYPE_SERVICE) &&
                    (i_port_type != `VPTF_TYPE_CUSTOM);

  assign o_tagged  = is_ctag || is_stag;
  // 0x8100 always passes; 0x88A8 only on service kinds  [R2] [R3] [R4] [R7]
  assign o_discard = is_stag && customer;

  always @* begin
    case (i_port_type)
      `VPTF_TYPE_SERVICE: o_port_tpid = `VPTF_TPID_STAG;  // [R6]
      `VPTF_TYPE_CUSTOM:  o_port_tpid = i_custom_tpid;
      default:            o_port_tpid = `VPTF_TPID_CTAG;  // [R5]
    endcase
  end

endmodule // vptf_tag_classify

`default_nettype wire

// file: vptf_port_filter.v
// Function
// (R1) Untagged received frames get a tag carrying the port default VLAN ID, then forward.
// (R2) Received frames tagged 0x8100 are forwarded on every port type.
// (R3) Customer ports discard received tagged frames whose TPID is not 0x8100.
// (R4) Service and custom-service ports discard tagged frames whose TPID is not 0x88A8; the code discards no tagged frame on these ports.
// (R5) Customer ports transmit tagged frames with TPID 0x8100.
// (R6) Service ports transmit tagged frames with TPID 0x88A8.
// (R7) Service kinds forward 0x8100 frames too; same choice on every port.
`timescale 1ns/1ps
`default_nettype none
`include "vptf_defs.vh"

module vptf_port_filter (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // Port setting
  input  wire [1:0]  i_port_type,
  input  wire [11:0] i_port_default_vlan_id,
  input  wire [15:0] i_custom_tpid,
  // Ingress from line
  input  wire        i_line_valid,
  input  wire [7:0]  i_line_data,
  input  wire        i_line_first,
  input  wire        i_line_last,
  output wire        o_line_ready,
  // Ingress to fabric
  output reg         o_fab_valid,
  output reg  [7:0]  o_fab_data,
  output reg         o_fab_first,
  output reg         o_fab_last,
  input  wire        i_fab_ready,
  // Egress from fabric
  input  wire        i_eg_valid,
  input  wire [7:0]  i_eg_data,
  input  wire        i_eg_first,
  input  wire        i_eg_last,
  input  wire        i_eg_tagged,
  output wire        o_eg_ready,
  // Egress to line
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_first,
  output reg         o_tx_last,
  input  wire        i_tx_ready
);

  localparam ST_HDR  = 2'h0;
  localparam ST_EMIT = 2'h1;
  localparam ST_PASS = 2'h2;
  localparam ST_DROP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////

  reg  [1:0]  state;
  reg  [7:0]  hdr [0:13];
  reg  [4:0]  hdr_cnt;
  reg  [4:0]  emit_idx;
  reg  [4:0]  emit_len;
  reg         hdr_last;
  reg         untagged;
  reg  [7:0]  emit_byte;
  reg  [3:0]  eg_idx;
  reg  [7:0]  eg_byte;

  wire        fab_free;
  wire        tx_free;
  wire        line_take;
  wire        hdr_done;
  wire        tag_seen;
  wire        tag_discard;
  wire [15:0] port_tpid;
  wire [3:0]  eg_cur_idx;
  wire        eg_take;
  wire [3:0]  hdr_wr_idx;

  assign fab_free  = !o_fab_valid || i_fab_ready;
  assign tx_free   = !o_tx_valid || i_tx_ready;
  // Header and drop phases never stall the line
  assign o_line_ready = (state == ST_HDR) || (state == ST_DROP) ||
                        ((state == ST_PASS) && fab_free);
  assign line_take = i_line_valid && o_line_ready;
  assign hdr_done  = (hdr_cnt == `VPTF_HDR_BYTES - 5'h01);

  vptf_tag_classify u_classify (
    .i_port_type  (i_port_type),
    .i_custom_tpid(i_custom_tpid),
    .i_ethertype  ({hdr[12], i_line_data}),
    .o_tagged     (tag_seen),
    .o_discard    (tag_discard),
    .o_port_tpid  (port_tpid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ingress header capture

  // A new start lands at entry zero, even in mid-capture
  assign hdr_wr_idx = i_line_first ? 4'h0 : hdr_cnt[3:0];

  always @(posedge i_ref_clk) begin
    if (line_take && (state == ST_HDR)) begin
      hdr[hdr_wr_idx] <= i_line_data;
    end
  end

  // Byte sent at each step of the header replay
  always @* begin
    emit_byte = 8'h00;
    if (!untagged || (emit_idx < `VPTF_ADDR_BYTES)) begin
      emit_byte = hdr[emit_idx[3:0]];
    end else begin
      case (emit_idx)
        5'h0C:   emit_byte = port_tpid[15:8];  // [R1]
        5'h0D:   emit_byte = port_tpid[7:0];  // [R1]
        5'h0E:   emit_byte = {`VPTF_TCI_PCP_DEI, i_port_default_vlan_id[11:8]};  // [R1]
        5'h0F:   emit_byte = i_port_default_vlan_id[7:0];  // [R1]
        5'h10:   emit_byte = hdr[12];
        5'h11:   emit_byte = hdr[13];
        default: emit_byte = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress state machine

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state    <= ST_HDR;
      hdr_cnt  <= 5'h00;
      emit_idx <= 5'h00;
      emit_len <= 5'h00;
      hdr_last <= 1'b0;
      untagged <= 1'b0;
    end else begin
      case (state)
        ST_HDR: begin
          if (line_take) begin
            if (i_line_first && (hdr_cnt != 5'h00)) begin
              // Resync on a new start; a one-byte frame is a runt
              hdr_cnt <= i_line_last ? 5'h00 : 5'h01;
            end else if (hdr_done) begin
              hdr_cnt  <= 5'h00;
              emit_idx <= 5'h00;
              hdr_last <= i_line_last;
              untagged <= !tag_seen;
              if (tag_seen && tag_discard) begin
                state <= i_line_last ? ST_HDR : ST_DROP;  // [R3] [R4]
              end else begin
                state    <= ST_EMIT;  // [R1] [R2] [R7]
                emit_len <= tag_seen ? `VPTF_HDR_BYTES : `VPTF_UNTAG_LEN;
              end
            end else if (i_line_last) begin
              // Runt shorter than a header is dropped
              hdr_cnt <= 5'h00;
            end else begin
              hdr_cnt <= hdr_cnt + 5'h01;
            end
          end
        end
        ST_EMIT: begin
          if (fab_free) begin
            emit_idx <= emit_idx + 5'h01;
            if (emit_idx == emit_len - 5'h01) begin
              state <= hdr_last ? ST_HDR : ST_PASS;
            end
          end
        end
        ST_PASS: begin
          if (line_take && i_line_last) begin
            state <= ST_HDR;
          end
        end
        ST_DROP: begin
          if (line_take && i_line_last) begin
            state <= ST_HDR;  // [R3] [R4]
          end
        end
        default: state <= ST_HDR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress output register

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_fab_valid <= 1'b0;
      o_fab_data  <= 8'h00;
      o_fab_first <= 1'b0;
      o_fab_last  <= 1'b0;
    end else if (fab_free) begin
      o_fab_valid <= 1'b0;
      if (state == ST_EMIT) begin
        o_fab_valid <= 1'b1;
        o_fab_data  <= emit_byte;
        o_fab_first <= (emit_idx == 5'h00);
        o_fab_last  <= hdr_last && (emit_idx == emit_len - 5'h01);
      end else if ((state == ST_PASS) && i_line_valid) begin
        o_fab_valid <= 1'b1;
        o_fab_data  <= i_line_data;
        o_fab_first <= 1'b0;
        o_fab_last  <= i_line_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress TPID rewrite, cut-through with no buffer

  assign o_eg_ready = tx_free;
  assign eg_take    = i_eg_valid && tx_free;
  assign eg_cur_idx = i_eg_first ? 4'h0 : eg_idx;

  always @* begin
    eg_byte = i_eg_data;
    if (i_eg_tagged && (eg_cur_idx == `VPTF_TPID_HI_IDX)) begin
      eg_byte = port_tpid[15:8];  // [R5] [R6]
    end else if (i_eg_tagged && (eg_cur_idx == `VPTF_TPID_LO_IDX)) begin
      eg_byte = port_tpid[7:0];  // [R5] [R6]
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      eg_idx     <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      o_tx_first <= 1'b0;
      o_tx_last  <= 1'b0;
    end else if (tx_free) begin
      o_tx_valid <= eg_take;
      if (eg_take) begin
        o_tx_data  <= eg_byte;
        o_tx_first <= i_eg_first;
        o_tx_last  <= i_eg_last;
        // Saturate: only the first fourteen positions matter
        eg_idx <= (eg_cur_idx == 4'hF) ? 4'hF : eg_cur_idx + 4'h1;
      end
    end
  end

endmodule // vptf_port_filter

`default_nettype wire

// file: vptf_port_filter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vptf_port_filter_sva (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  // Observed streams
  input wire logic [1:0] i_port_type,
  input wire logic       i_fab_ready,
  input wire logic       o_fab_valid,
  input wire logic [7:0] o_fab_data,
  input wire logic       o_fab_last,
  input wire logic       o_fab_first,
  input wire logic       i_eg_tagged,
  input wire logic       o_eg_ready,
  input wire logic       o_tx_first,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_last,
  input wire logic       i_tx_ready
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [4:0] fpos;
  logic [4:0] tpos;
  ////////////////////////////////////////
  // Byte positions, so header bytes can be picked out
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fpos <= 5'h00;
      tpos <= 5'h00;
    end else begin
      if (o_fab_valid && i_fab_ready) fpos <= o_fab_last ? 5'h00 : fpos + 5'h01;
      if (o_tx_valid && i_tx_ready) tpos <= o_tx_last ? 5'h00 : tpos + 5'h01;
    end
  end
  sequence fab_hi; o_fab_valid && fpos == 5'h0C; endsequence
  sequence tx_hi; o_tx_valid && i_eg_tagged && tpos == 5'h0C; endsequence
  cust_ingress_a: assert property (fab_hi ##0 i_port_type == 2'h0 |-> o_fab_data == 8'h81)
    else $error("customer ingress tag wrong");
  svc_ingress_a: assert property (fab_hi ##0 i_port_type == 2'h1 |-> o_fab_data inside {8'h81, 8'h88})
    else $error("service ingress tag wrong");
  fab_hold_a: assert property (o_fab_valid && !i_fab_ready |=> o_fab_valid && $stable(o_fab_data))
    else $error("fabric byte dropped");
  tx_cust_a: assert property (tx_hi ##0 i_port_type == 2'h0 |-> o_tx_data == 8'h81)
    else $error("customer egress tag wrong");
  tx_svc_a: assert property (tx_hi ##0 i_port_type == 2'h1 |-> o_tx_data == 8'h88 ##1 1'b1)
    else $error("service egress tag wrong");
  tx_svc_lo_a: assert property (o_tx_valid && i_eg_tagged && tpos == 5'h0D && i_port_type == 2'h1 |-> o_tx_data == 8'hA8)
    else $error("service egress tag low wrong");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("line byte dropped");
  fab_first_a: assert property (o_fab_valid |-> o_fab_first == (fpos == 5'h00))
    else $error("fabric frame start wrong");
  tx_first_a: assert property (o_tx_valid |-> o_tx_first == (tpos == 5'h00))
    else $error("line frame start wrong");
  eg_ready_a: assert property (o_eg_ready == (!o_tx_valid || i_tx_ready))
    else $error("egress ready wrong");
endmodule // vptf_port_filter_sva
bind vptf_port_filter vptf_port_filter_sva u_sva (
  .i_ref_clk  (i_ref_clk),
  .i_rst      (i_rst),
  .i_port_type(i_port_type),
  .i_fab_ready(i_fab_ready),
  .o_fab_valid(o_fab_valid),
  .o_fab_data (o_fab_data),
  .o_fab_last (o_fab_last),
  .o_fab_first(o_fab_first),
  .i_eg_tagged(i_eg_tagged),
  .o_eg_ready (o_eg_ready),
  .o_tx_first (o_tx_first),
  .o_tx_valid (o_tx_valid),
  .o_tx_data  (o_tx_data),
  .o_tx_last  (o_tx_last),
  .i_tx_ready (i_tx_ready)
);
`default_nettype wire

// file: vptf_frame_source.sv
`timescale 1ns/1ps
`default_nettype none
module vptf_frame_source (
  // Byte stream out
  input  wire logic       i_ref_clk,
  input  wire logic       i_ready,
  output var  logic       o_valid = 1'b0,
  output var  logic [7:0] o_data = 8'h00,
  output var  logic       o_first = 1'b0,
  output var  logic       o_last = 1'b0
);
  ////////////////////////////////////////
  // Idle data inverted so a stale byte never looks fresh
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      o_valid <= 1'b1;
      o_data  <= f[i];
      o_first <= i == 0;
      o_last  <= i == f.size() - 1;
      do @(negedge i_ref_clk); while (!i_ready);
      @(posedge i_ref_clk);
    end
    o_valid <= 1'b0;
    o_data  <= ~f[f.size() - 1];
  endtask
endmodule // vptf_frame_source
`default_nettype wire

// file: tb_vlan_port_type_tag_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vlan_port_type_tag_filter;
  logic        clk = 1'b0, rst = 1'b1, fab_rdy = 1'b0, tx_rdy = 1'b0, eg_tag = 1'b0;
  logic [1:0]  ptype = 2'h0;
  logic [11:0] vid = 12'h000;
  logic [15:0] ctp = 16'h0000;
  logic [31:0] seed = 32'h0000_0006;
  logic [7:0]  fq[$], tq[$];
  int          num_errors = 0, tests_run = 0;
  wire         lv, lf, ll, lrdy, ev, ef, el, erdy, fv, ff, fl, tv, tf, tl;
  wire  [7:0]  ld, ed, fd, td;
  always #25 clk = ~clk;
  vptf_frame_source lp (.i_ref_clk(clk), .i_ready(lrdy), .o_valid(lv), .o_data(ld),
    .o_first(lf), .o_last(ll));
  vptf_frame_source es (.i_ref_clk(clk), .i_ready(erdy), .o_valid(ev), .o_data(ed),
    .o_first(ef), .o_last(el));
  vptf_port_filter DUT (.i_ref_clk(clk), .i_rst(rst), .i_port_type(ptype),
    .i_port_default_vlan_id(vid), .i_custom_tpid(ctp), .i_line_valid(lv), .i_line_data(ld),
    .i_line_first(lf), .i_line_last(ll), .o_line_ready(lrdy), .o_fab_valid(fv),
    .o_fab_data(fd), .o_fab_first(ff), .o_fab_last(fl), .i_fab_ready(fab_rdy),
    .i_eg_valid(ev), .i_eg_data(ed), .i_eg_first(ef), .i_eg_last(el), .i_eg_tagged(eg_tag),
    .o_eg_ready(erdy), .o_tx_valid(tv), .o_tx_data(td), .o_tx_first(tf), .o_tx_last(tl),
    .i_tx_ready(tx_rdy));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Random stalls on both sinks
  always @(posedge clk) begin
    if (fv && fab_rdy) begin
      check("fab_data", fd, fq.pop_front());
      check("fab_last", 8'(fl), 8'(fq.size() == 0));
    end
    if (tv && tx_rdy) begin
      check("tx_data", td, tq.pop_front());
      check("tx_last", 8'(tl), 8'(tq.size() == 0));
    end
    fab_rdy <= rnd() % 4 != 0;
    tx_rdy  <= rnd() % 3 != 0;
  end
  initial begin : main
    logic [7:0]  f[$], g[$], e[$];
    logic [15:0] tp, ety;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 3; k++) begin
        ptype <= 2'(t);
        eg_tag <= k != 0;
        vid   <= 12'(rnd());
        ctp   <= 16'(rnd());
        @(posedge clk);
        ety = k == 0 ? 16'h0800 : k == 1 ? 16'h8100 : 16'h88A8;
        // Type code 3 behaves as customer
        tp  = t == 1 ? 16'h88A8 : t == 2 ? ctp : 16'h8100;
        f = {};
        g = {};
        for (int i = 0; i < 20; i++) begin
          f.push_back(8'(rnd()));
          g.push_back(8'(rnd()));
        end
        f[12] = ety[15:8];
        f[13] = ety[7:0];
        e = f;
        if (k == 0) e = {f[0:11], tp[15:8], tp[7:0], 8'(vid[11:8]), vid[7:0], f[12:19]};
        if (k == 2 && (t == 0 || t == 3)) e = {};
        fq = {fq, e};
        e = g;
        if (eg_tag) e[12] = tp[15:8];
        if (eg_tag) e[13] = tp[7:0];
        tq = {tq, e};
        fork
          lp.send(f);
          es.send(g);
        join
        for (int n = 0; n < 400 && fq.size() + tq.size() > 0; n++) @(posedge clk);
      end
    end
    check("left_over", 8'(fq.size() + tq.size()), 8'h00);
    tally_and_finish();
  end
  initial begin
    #(50 * 20000);
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_vlan_port_type_tag_filter
`default_nettype wire
